// ===== common/sw_ctrl_map.svh
// Constants of the switch control front end: address, register slots, fields and defaults.
// Assumes it is included by bare name wherever the numbers are needed.
`ifndef SW_CTRL_MAP_SVH
`define SW_CTRL_MAP_SVH
// ----------------------------------------
// Slave address and framing
// ----------------------------------------
`define ADDR_FIXED 4'h9
`define BYTE_BITS 4'h8
`define INIT_CYC 2'h3
// ----------------------------------------
// Serial register slots and defaults
// ----------------------------------------
`define REG_NUM 4
`define IDX_HI 1
`define REG_HS 2'h0
`define REG_AUX 2'h1
`define REG_RX 2'h2
`define REG_TX 2'h3
`define HS_DEF 8'h40
`define AUX_DEF 8'h40
`define RX_DEF 8'h00
`define TX_DEF 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define EN_BIT 6
`define MODE_HI 5
`define MODE_LO 4
`define SRC_HI 3
`define SRC_LO 0
`define EQ_BIT 0
`define TERM_BIT 3
`define CUR_BIT 2
`define BOOST_HI 1
`define BOOST_LO 0
`define QUAD_MODE 2'h0
`define SRC_PAD 2'h0
`endif

// ===== common/sw_ctrl_pkg.sv
// Types of the switch control front end.
// Assumes sw_ctrl_map.svh supplies the numeric constants.
package sw_ctrl_pkg;
  // ----------------------------------------
  // Pin groups and configuration carriers
  // ----------------------------------------
  typedef struct packed {
    logic out_en;
    logic [1:0] src;
    logic eq;
    logic [1:0] boost;
    logic term;
    logic cur;
  } par_cfg_t;

  typedef struct packed {
    par_cfg_t par;
    logic [2:0] strap;
    logic sda;
    logic scl;
  } pin_t;

  typedef struct packed {
    logic out_en;
    logic [1:0] hs_mode;
    logic [3:0] hs_src;
    logic aux_en;
    logic [1:0] aux_mode;
    logic [3:0] aux_src;
    logic eq;
    logic [1:0] boost;
    logic out_termination_ctrl;
    logic out_current_level_ctrl;
  } eff_cfg_t;

  // ----------------------------------------
  // Serial engine states and module state
  // ----------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_PTR = 9'h008,
    ST_PTR_ACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK = 9'h100
  } fsm_t;

  typedef struct packed {
    pin_t s1;
    pin_t s2;
    logic prev_scl;
    logic prev_sda;
    fsm_t fsm;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic drive;
    logic acked;
    logic serial;
    logic [1:0] init;
    logic [3:0][7:0] regs;
    par_cfg_t par;
    eff_cfg_t cfg;
  } st_t;
endpackage

// ===== src/switch_control_interface.sv
// Control front end of a link switch: two-wire slave, parallel pins and control arbitration.
// Assumes every pin input is asynchronous to mclk_in and the data line wire is resolved outside.
`timescale 1ns/100ps
`include "sw_ctrl_map.svh"

module switch_control_interface
  import sw_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Address straps
  input wire logic slave_addr_strap_bit2_in,
  input wire logic slave_addr_strap_bit1_in,
  input wire logic slave_addr_strap_bit0_in,
  // Parallel control pins
  input wire logic par_output_enable_pin_in,
  input wire logic [1:0] par_source_select_pins_in,
  input wire logic par_equalizer_pin_in,
  input wire logic [1:0] par_boost_level_pins_in,
  input wire logic par_out_termination_pin_in,
  input wire logic par_out_current_pin_in,
  // Effective configuration
  output eff_cfg_t cfg_out,
  output logic serial_ctrl_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic reg_hit(input logic [7:0] p);
    return p < 8'(`REG_NUM);
  endfunction

  function automatic logic [7:0] rd_reg(input logic [3:0][7:0] r, input logic [7:0] p);
    return reg_hit(p) ? r[p[`IDX_HI:0]] : 8'h00;
  endfunction

  // ----------------------------------------
  // State and line events
  // ----------------------------------------
  st_t q;
  st_t n;
  pin_t pins;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic addr_ok;
  logic [7:0] rd_val;

  assign pins = '{par: '{out_en: par_output_enable_pin_in, src: par_source_select_pins_in,
                         eq: par_equalizer_pin_in, boost: par_boost_level_pins_in,
                         term: par_out_termination_pin_in, cur: par_out_current_pin_in},
                  strap: {slave_addr_strap_bit2_in, slave_addr_strap_bit1_in,
                          slave_addr_strap_bit0_in},
                  sda: sda_in, scl: scl_in};

  // Edges and bus conditions look only at the second stage and its history.
  assign rise = q.s2.scl & ~q.prev_scl;
  assign fall = ~q.s2.scl & q.prev_scl;
  assign start = q.s2.scl & q.prev_scl & q.prev_sda & ~q.s2.sda;
  assign stop = q.s2.scl & q.prev_scl & ~q.prev_sda & q.s2.sda;
  assign addr_ok = q.sh[7:1] == {`ADDR_FIXED, q.s2.strap};
  assign rd_val = rd_reg(q.regs, q.ptr);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = q;
    n.s1 = pins;
    n.s2 = q.s1;
    n.prev_scl = q.s2.scl;
    n.prev_sda = q.s2.sda;
    n.par = q.s2.par;
    // Pin capture runs a few cycles so the value has crossed both stages.
    if (q.init != 2'h0) begin
      n.init = q.init - 2'h1;
      n.regs[`REG_TX][`TERM_BIT] = q.s2.par.term;
      n.regs[`REG_TX][`CUR_BIT] = q.s2.par.cur;
    end
    if (stop) begin
      n.fsm = ST_IDLE;
      n.drive = 1'b0;
    end else if (start) begin
      n.fsm = ST_ADDR;
      n.cnt = 4'h0;
      n.drive = 1'b0;
    end else begin
      unique case (q.fsm)
        ST_IDLE: begin
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (rise) begin
            n.sh = {q.sh[6:0], q.s2.sda};
            n.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == `BYTE_BITS) begin
            n.drive = 1'b1;
            if (q.fsm == ST_ADDR) begin
              // A foreign address leaves the line alone until the next start.
              n.fsm = addr_ok ? ST_ADDR_ACK : ST_IDLE;
              n.drive = addr_ok;
              n.serial = q.serial | addr_ok;
              n.rw = q.sh[0];
            end else if (q.fsm == ST_PTR) begin
              n.ptr = q.sh;
              n.fsm = ST_PTR_ACK;
            end else begin
              if (reg_hit(q.ptr)) begin
                n.regs[q.ptr[`IDX_HI:0]] = q.sh;
              end
              n.fsm = ST_WACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (fall) begin
            n.cnt = 4'h0;
            if (q.rw) begin
              n.sh = rd_val;
              n.drive = ~rd_val[7];
              n.fsm = ST_RDATA;
            end else begin
              n.drive = 1'b0;
              n.fsm = ST_PTR;
            end
          end
        end
        ST_PTR_ACK, ST_WACK: begin
          if (fall) begin
            n.drive = 1'b0;
            n.cnt = 4'h0;
            n.fsm = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (rise) begin
            n.cnt = q.cnt + 4'h1;
          end else if (fall) begin
            if (q.cnt == `BYTE_BITS) begin
              n.drive = 1'b0;
              n.fsm = ST_RACK;
            end else begin
              n.sh = {q.sh[6:0], 1'b0};
              n.drive = ~q.sh[6];
            end
          end
        end
        ST_RACK: begin
          if (rise) begin
            n.acked = ~q.s2.sda;
          end else if (fall) begin
            n.cnt = 4'h0;
            n.sh = rd_val;
            n.drive = q.acked & ~rd_val[7];
            n.fsm = q.acked ? ST_RDATA : ST_IDLE;
          end
        end
      endcase
    end
    // Effective settings: parallel copy until the serial side has been addressed.
    if (q.serial) begin
      n.cfg.out_en = q.regs[`REG_HS][`EN_BIT];
      n.cfg.hs_mode = q.regs[`REG_HS][`MODE_HI:`MODE_LO];
      n.cfg.hs_src = q.regs[`REG_HS][`SRC_HI:`SRC_LO];
      n.cfg.aux_en = q.regs[`REG_AUX][`EN_BIT];
      n.cfg.aux_mode = q.regs[`REG_AUX][`MODE_HI:`MODE_LO];
      n.cfg.aux_src = q.regs[`REG_AUX][`SRC_HI:`SRC_LO];
      n.cfg.eq = q.regs[`REG_RX][`EQ_BIT];
      n.cfg.boost = q.regs[`REG_TX][`BOOST_HI:`BOOST_LO];
      n.cfg.out_termination_ctrl = q.regs[`REG_TX][`TERM_BIT];
      n.cfg.out_current_level_ctrl = q.regs[`REG_TX][`CUR_BIT];
    end else begin
      n.cfg.out_en = q.par.out_en;
      n.cfg.hs_mode = `QUAD_MODE;
      n.cfg.hs_src = {`SRC_PAD, q.par.src};
      n.cfg.aux_en = q.par.out_en;
      n.cfg.aux_mode = `QUAD_MODE;
      n.cfg.aux_src = {`SRC_PAD, q.par.src};
      n.cfg.eq = q.par.eq;
      n.cfg.boost = q.par.boost;
      n.cfg.out_termination_ctrl = q.par.term;
      n.cfg.out_current_level_ctrl = q.par.cur;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.fsm <= ST_IDLE;
      q.init <= `INIT_CYC;
      // Line stages start at the idle bus level so that release shows no false edge.
      q.s1 <= '{par: '0, strap: 3'h0, sda: 1'b1, scl: 1'b1};
      q.s2 <= '{par: '0, strap: 3'h0, sda: 1'b1, scl: 1'b1};
      q.prev_scl <= 1'b1;
      q.prev_sda <= 1'b1;
      q.regs[`REG_HS] <= `HS_DEF;
      q.regs[`REG_AUX] <= `AUX_DEF;
      q.regs[`REG_RX] <= `RX_DEF;
      q.regs[`REG_TX] <= `TX_DEF;
    end else begin
      q <= n;
    end
  end

  // The data line is only ever pulled low; the level comes from the pull-up.
  assign sda_out = 1'b0;
  assign sda_oe_n_out = ~q.drive;
  assign cfg_out = q.cfg;
  assign serial_ctrl_out = q.serial;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // The reset check must see reset itself, so it opts out of the default disable.
  a_reset_defaults: assert property (disable iff (1'b0) !rst_n_in |=>
      q.regs[`REG_HS] == `HS_DEF && q.regs[`REG_AUX] == `AUX_DEF && !q.serial)
    else $error("Registers not at defaults after reset.");
  a_par_follow: assert property (!q.serial |=> q.cfg.boost == $past(q.par.boost))
    else $error("Parallel settings not followed.");
  a_serial_sticky: assert property (q.serial |=> q.serial)
    else $error("Serial control lost before reset.");
  a_serial_takes: assert property (q.serial |=>
      q.cfg.hs_src == $past(q.regs[`REG_HS][`SRC_HI:`SRC_LO]))
    else $error("Serial settings not applied.");
  a_par_quad: assert property (!q.serial |=>
      q.cfg.hs_mode == `QUAD_MODE && q.cfg.aux_src == q.cfg.hs_src)
    else $error("Parallel control left quad mode.");
  a_addr_ack: assert property ($rose(q.fsm == ST_ADDR_ACK) |->
      q.sh[7:4] == `ADDR_FIXED && q.drive && q.serial)
    else $error("Acknowledged a foreign address.");
  a_idle_quiet: assert property (q.fsm == ST_IDLE |-> !q.drive)
    else $error("Line pulled while idle.");
  a_write_store: assert property ($rose(q.fsm == ST_WACK) && reg_hit(q.ptr) |->
      q.regs[q.ptr[`IDX_HI:0]] == q.sh)
    else $error("Write byte not stored.");
  a_read_msb: assert property ($rose(q.fsm == ST_RDATA) |->
      q.drive == ~q.sh[7] && q.sh == rd_val)
    else $error("Read byte not started at MSB.");
  a_ptr_kept: assert property (q.fsm == ST_RDATA |=> $stable(q.ptr))
    else $error("Pointer moved during read.");
  a_pin_capture: assert property (q.init != 2'h0 |=>
      q.regs[`REG_TX][`TERM_BIT] == $past(q.s2.par.term))
    else $error("Termination not taken from pin.");

endmodule // switch_control_interface

// ===== verif/i2c_master_model.sv
// Behavioural two-wire bus master that drives the clock line and the data line.
// Assumes a pull-up on the data line, resolved by the bench from all pull-downs.
`timescale 1ns/100ps

module i2c_master_model (
  // Clock and resolved data line
  input wire logic clk_in,
  input wire logic sda_in,
  // Lines driven by the master, 1 means released
  output logic scl_out,
  output logic sda_out
);
  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  // Each phase lasts at least 10 clocks so the synchronised device sees every level.
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic hold();
    repeat (10) @(posedge clk_in);
  endtask

  // Start and repeated start share one sequence; it begins by releasing the data line, with the clock low only for a repeated start.
  task automatic start();
    sda_out <= 1'b1;
    hold();
    scl_out <= 1'b1;
    hold();
    sda_out <= 1'b0;
    hold();
    scl_out <= 1'b0;
    hold();
  endtask

  task automatic stop();
    sda_out <= 1'b0;
    hold();
    scl_out <= 1'b1;
    hold();
    sda_out <= 1'b1;
    hold();
  endtask

  // Data changes only while the clock is low, so no false start or stop occurs.
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    hold();
    scl_out <= 1'b1;
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    r = sda_in;
    hold();
    scl_out <= 1'b0;
    hold();
  endtask

  // Bytes go most significant bit first; ack_in is the master's own acknowledge.
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask
endmodule // i2c_master_model

// ===== verif/tb_top.sv
// Self-checking bench of the switch control front end.
// Assumes the design's own assertions are compiled with it.
`timescale 1ns/100ps
`include "sw_ctrl_map.svh"

module tb_top
  import sw_ctrl_pkg::*;
;
  // ----------------------------------------
  // Clock, pins and instances
  // ----------------------------------------
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] strap = 3'h5;
  par_cfg_t par = '{1'b1, 2'h2, 1'b1, 2'h1, 1'b1, 1'b0};
  logic scl, m_sda, sda_out, sda_oe_n_out, serial_ctrl_out;
  eff_cfg_t cfg_out;
  wire sda_w = m_sda & (sda_oe_n_out | sda_out);
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // The address follows the straps, so a strap change moves it during the run.
  wire [6:0] dev_addr = {`ADDR_FIXED, strap};
  logic [7:0] ptrs [5] = '{8'h07, 8'h00, 8'h01, 8'h02, 8'h03};
  logic [7:0] vals [5] = '{8'h00, 8'h53, 8'h25, 8'h01, 8'h0A};

  always #2 mclk_in = ~mclk_in;

  i2c_master_model m (.clk_in(mclk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));

  switch_control_interface DUT (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .slave_addr_strap_bit2_in(strap[2]), .slave_addr_strap_bit1_in(strap[1]),
    .slave_addr_strap_bit0_in(strap[0]), .par_output_enable_pin_in(par.out_en),
    .par_source_select_pins_in(par.src), .par_equalizer_pin_in(par.eq),
    .par_boost_level_pins_in(par.boost), .par_out_termination_pin_in(par.term),
    .par_out_current_pin_in(par.cur), .cfg_out(cfg_out), .serial_ctrl_out(serial_ctrl_out)
  );

  // ----------------------------------------
  // Checking and access tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well above the roughly 25000 cycles the tests need.
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Parallel control has quad mode only and auxiliary follows the source pins.
  function automatic eff_cfg_t pexp(par_cfg_t p);
    return '{p.out_en, `QUAD_MODE, {`SRC_PAD, p.src}, p.out_en, `QUAD_MODE,
             {`SRC_PAD, p.src}, p.eq, p.boost, p.term, p.cur};
  endfunction

  function automatic eff_cfg_t sexp(logic [7:0] hs, logic [7:0] aux, logic [7:0] rx,
                                    logic [7:0] tx);
    return '{hs[6], hs[5:4], hs[3:0], aux[6], aux[5:4], aux[3:0], rx[0], tx[1:0],
             tx[3], tx[2]};
  endfunction

  task automatic do_reset();
    rst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
  endtask

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] q;
    logic a;
    m.start();
    m.xfer({dev_addr, 1'b0}, 1'b1, q, a);
    chk(a, 0);
    m.xfer(ptr, 1'b1, q, a);
    chk(a, 0);
    m.xfer(d, 1'b1, q, a);
    chk(a, 0);
    m.stop();
  endtask

  // Two bytes per read: the master acknowledges the first, the same register comes again.
  task automatic read_reg(input logic [7:0] ptr, input logic [7:0] exp, input logic set_ptr);
    logic [7:0] q;
    logic a;
    if (set_ptr) begin
      m.start();
      m.xfer({dev_addr, 1'b0}, 1'b1, q, a);
      m.xfer(ptr, 1'b1, q, a);
    end
    m.start();
    m.xfer({dev_addr, 1'b1}, 1'b1, q, a);
    chk(a, 0);
    m.xfer(8'hFF, 1'b0, q, a);
    chk(q, exp);
    m.xfer(8'hFF, 1'b1, q, a);
    chk(q, exp);
    m.stop();
  endtask

  task automatic bad_addr(input logic [6:0] adr);
    logic [7:0] q;
    logic a;
    m.start();
    m.xfer({adr, 1'b0}, 1'b1, q, a);
    chk(a, 1);
    m.stop();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    chk(cfg_out, pexp(par));
    chk(serial_ctrl_out, 0);
    par <= '{1'b0, 2'h3, 1'b0, 2'h2, 1'b0, 1'b1};
    repeat (10) @(posedge mclk_in);
    chk(cfg_out, pexp(par));
    bad_addr({4'h8, 3'h5});
    bad_addr({`ADDR_FIXED, 3'h4});
    chk(serial_ctrl_out, 0);
    chk(cfg_out, pexp(par));
    write_reg(`REG_HS, 8'h53);
    chk(serial_ctrl_out, 1);
    write_reg(`REG_AUX, 8'h25);
    write_reg(`REG_RX, 8'h01);
    write_reg(`REG_TX, 8'h0A);
    write_reg(8'h07, 8'h77);
    par <= '{1'b1, 2'h1, 1'b1, 2'h3, 1'b1, 1'b1};
    repeat (10) @(posedge mclk_in);
    chk(cfg_out, sexp(8'h53, 8'h25, 8'h01, 8'h0A));
    for (int i = 0; i < 5; i++) begin
      read_reg(ptrs[i], vals[i], 1'b1);
    end
    read_reg(8'h00, 8'h0A, 1'b0);
    // Mid-run reset: defaults return except the TX bits taken from the pins, and the pins rule again.
    do_reset();
    chk(serial_ctrl_out, 0);
    chk(cfg_out, pexp(par));
    read_reg(`REG_HS, `HS_DEF, 1'b1);
    read_reg(`REG_AUX, `AUX_DEF, 1'b1);
    read_reg(`REG_RX, `RX_DEF, 1'b1);
    read_reg(`REG_TX, {4'h0, par.term, par.cur, 2'h0}, 1'b1);
    // New straps: the old address goes unanswered and the new one is served.
    strap <= 3'h2;
    repeat (10) @(posedge mclk_in);
    bad_addr({`ADDR_FIXED, 3'h5});
    read_reg(`REG_HS, `HS_DEF, 1'b1);
    report_and_stop();
  end
endmodule // tb_top
